// file: common/udh_pkg.sv
// Purpose: constants and helpers of the ultra/multiword host channel
// Assumes: one channel; timing chosen per drive at engage
// Notes:   field lsb names pair the multiword and ultra meanings
package udh_pkg;
    localparam logic [7:0]  OFS_T0      = 8'h24;
    localparam logic [7:0]  OFS_T1      = 8'h2C;
    localparam logic [7:0]  OFS_T2      = 8'h34;
    localparam logic [7:0]  OFS_T3      = 8'h3C;
    localparam logic [31:0] RST_T0      = 32'h00077771;
    localparam logic [31:0] RST_TN      = 32'h00017771;
    localparam logic [31:0] WMASK       = 32'h801FFFFF;
    localparam int          B_PIOFMT    = 31;
    localparam int          B_UDMA      = 20;
    localparam int          LSB_REC_CRC = 16;
    localparam int          LSB_PUL_SS  = 12;
    localparam int          LSB_WRC_CYC = 8;
    localparam int          LSB_WPL_RP  = 4;
    localparam int          LSB_SETUP   = 0;
    localparam int          PRD_EOT     = 31;
    localparam logic [31:0] PRD_STEP    = 32'h00000008;
    localparam logic [31:0] WORD_STEP   = 32'h00000004;
    localparam logic [31:0] HALF_STEP   = 32'h00000002;
    localparam logic [15:0] SZ_MAX      = 16'h8000;
    localparam logic [15:0] CRC_SEED    = 16'h4ABA;
    localparam logic [15:0] CRC_POLY    = 16'h1021;

    function automatic logic [15:0] crc_upd(input logic [15:0] c,
                                            input logic [15:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 15; i >= 0; i--) begin
            r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? CRC_POLY : 16'h0000);
        end
        crc_upd = r;
    endfunction

    function automatic logic [4:0] fld(input logic [31:0] c, input int lsb);
        fld = {1'b0, c[lsb +: 4]};
    endfunction

    // hit flag on top, register index below
    function automatic logic [2:0] ridx(input logic [7:0] a);
        case (a)
            OFS_T0:  ridx = 3'h4;
            OFS_T1:  ridx = 3'h5;
            OFS_T2:  ridx = 3'h6;
            OFS_T3:  ridx = 3'h7;
            default: ridx = 3'h0;
        endcase
    endfunction
endpackage

// file: hw/udh_top.sv
// Purpose: host channel for ultra and multiword DMA with descriptor master
// Assumes: memory port returns a one-cycle ack; cable on link_clk_i
// Notes:   one-word mailbox between domains, so reads pause per word
`timescale 1ns/1ps
module udh_top
    import udh_pkg::*;
(
    // core clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    // timing register port
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [31:0] reg_wdata_i,
    output logic      [31:0] reg_rdata_o,
    // bus master control
    input  wire logic        bm_enable_i,
    input  wire logic        bm_to_memory_i,
    input  wire logic [31:0] prd_table_addr_i,
    input  wire logic [1:0]  drive_select_i,
    output logic             bm_active_o,
    output logic             bm_error_o,
    // memory master
    output logic             mem_rd_o,
    output logic             mem_wr_o,
    output logic      [31:0] mem_addr_o,
    output logic      [15:0] mem_wdata_o,
    input  wire logic        mem_ack_i,
    input  wire logic [31:0] mem_rdata_i,
    // cable side
    input  wire logic        link_clk_i,
    input  wire logic        drive_dma_request_i,
    input  wire logic        cable_ready_input_i,
    input  wire logic [15:0] cable_data_bus_i,
    output logic             cable_write_strobe_n_o,
    output logic             cable_read_strobe_n_o,
    output logic             host_dma_acknowledge_n_o,
    output logic             cable_chip_select_a_n_o,
    output logic             cable_chip_select_b_n_o,
    output logic      [2:0]  cable_register_addr_o,
    output logic      [15:0] cable_data_bus_o,
    output logic             cable_data_bus_oe_o
);

// ----------------------------------------
// state types
// ----------------------------------------
typedef enum logic [2:0] {
    C_IDLE, C_FA, C_FB, C_MOVE, C_MEM, C_FIN
} udh_cst_t;

typedef enum logic [3:0] {
    L_IDLE, L_ACK, L_XFER, L_WSET, L_RPAU, L_STPW,
    L_SHI, L_CRC, L_REL, L_MREC, L_MPUL
} udh_lst_t;

typedef struct packed {
    udh_cst_t         st;
    logic [3:0][31:0] tr;
    logic [31:0]      rdat;
    logic [31:0]      ptr;
    logic [31:0]      badr;
    logic [31:0]      adr;
    logic [31:0]      cfg;
    logic [15:0]      rem;
    logic [15:0]      mbd;
    logic [15:0]      wdat;
    logic             end_of_table_flag;
    logic             tom;
    logic             udma;
    logic             en_d;
    logic             act;
    logic             err;
    logic             run;
    logic             hst;
    logic             rd;
    logic             wr;
    logic             mbt;
    logic             lb_m;
    logic             lb_s;
    logic             ak_m;
    logic             ak_s;
    logic             er_m;
    logic             er_s;
} udh_core_t;

typedef struct packed {
    udh_lst_t    st;
    logic [4:0]  cnt;
    logic        rs_m;
    logic        rs_s;
    logic        dq_m;
    logic        dq_s;
    logic        ry_m;
    logic        ry_s;
    logic        ry_d;
    logic [15:0] dm;
    logic [15:0] ds;
    logic        rn_m;
    logic        rn_s;
    logic        hs_m;
    logic        hs_s;
    logic        mb_m;
    logic        mb_s;
    logic        lbt;
    logic [15:0] lbd;
    logic [15:0] crc;
    logic        iow;
    logic        ior;
    logic        dak;
    logic        cs;
    logic [2:0]  adr;
    logic [15:0] dout;
    logic        doe;
    logic        err;
    logic        hak;
    logic        wrd;
    logic        ud;
} udh_link_t;

udh_core_t cr;
udh_core_t cr_next;
udh_link_t lk;
udh_link_t lk_next;
logic [2:0]  ri;
logic [31:0] rmask;
logic        even;
logic        cap;

// ----------------------------------------
// core domain: registers and bus master
// ----------------------------------------
assign ri = ridx(reg_addr_i);
assign rmask = (ri[1:0] != 2'h0 && cr.tr[0][B_PIOFMT]) ?
               (WMASK & 32'h7FFFFFFF) : WMASK;

always_comb begin
    cr_next = cr;
    cr_next.lb_m = lk.lbt;
    cr_next.lb_s = cr.lb_m;
    cr_next.ak_m = lk.hak;
    cr_next.ak_s = cr.ak_m;
    cr_next.er_m = lk.err;
    cr_next.er_s = cr.er_m;
    cr_next.en_d = bm_enable_i;
    cr_next.rdat = '0;
    if (reg_rd_i && ri[2]) begin
        cr_next.rdat = cr.tr[ri[1:0]] & rmask;
    end
    if (reg_wr_i && ri[2]) begin
        cr_next.tr[ri[1:0]] = (reg_wdata_i & rmask) | (cr.tr[ri[1:0]] & ~rmask);
    end
    unique case (cr.st)
        C_IDLE: begin
            if (bm_enable_i && !cr.en_d) begin
                cr_next.ptr = prd_table_addr_i;
                cr_next.adr = prd_table_addr_i;
                cr_next.cfg = cr.tr[drive_select_i];
                cr_next.udma = cr.tr[0][B_UDMA];
                cr_next.tom = bm_to_memory_i;
                cr_next.act = 1'b1;
                cr_next.err = 1'b0;
                cr_next.run = 1'b1;
                cr_next.rd = 1'b1;
                cr_next.st = C_FA;
            end
        end
        C_FA: begin
            if (mem_ack_i) begin
                cr_next.badr = {mem_rdata_i[31:4], 4'h0};
                cr_next.adr = cr.ptr + WORD_STEP;
                cr_next.st = C_FB;
            end
        end
        C_FB: begin
            if (mem_ack_i) begin
                cr_next.rd = 1'b0;
                cr_next.end_of_table_flag = mem_rdata_i[PRD_EOT];
                cr_next.rem = (mem_rdata_i[15:4] == 12'h000) ? SZ_MAX :
                              {1'b0, mem_rdata_i[15:4], 3'h0};
                cr_next.ptr = cr.ptr + PRD_STEP;
                cr_next.st = C_MOVE;
            end
        end
        C_MOVE: begin
            if (!bm_enable_i) begin
                cr_next.hst = 1'b1;
                cr_next.st = C_FIN;
            end else if (cr.rem == 16'h0000) begin
                if (cr.end_of_table_flag) begin
                    cr_next.hst = 1'b1;
                    cr_next.st = C_FIN;
                end else begin
                    cr_next.rd = 1'b1;
                    cr_next.adr = cr.ptr;
                    cr_next.st = C_FA;
                end
            end else if (!cr.tom && cr.lb_s == cr.mbt) begin
                cr_next.rd = 1'b1;
                cr_next.adr = cr.badr;
                cr_next.st = C_MEM;
            end else if (cr.tom && cr.lb_s != cr.mbt) begin
                cr_next.wr = 1'b1;
                cr_next.adr = cr.badr;
                cr_next.wdat = lk.lbd;
                cr_next.st = C_MEM;
            end
        end
        C_MEM: begin
            if (mem_ack_i) begin
                cr_next.rd = 1'b0;
                cr_next.wr = 1'b0;
                if (!cr.tom) begin
                    cr_next.mbd = mem_rdata_i[15:0];
                end
                cr_next.mbt = !cr.mbt;
                cr_next.badr = cr.badr + HALF_STEP;
                cr_next.rem = cr.rem - 16'h0001;
                cr_next.st = C_MOVE;
            end
        end
        C_FIN: begin
            if (cr.ak_s) begin
                cr_next.err = cr.err | cr.er_s;
                cr_next.act = 1'b0;
                cr_next.run = 1'b0;
                cr_next.hst = 1'b0;
                cr_next.st = C_IDLE;
            end
        end
    endcase
    if (!rst_n_i) begin
        cr_next = '0;
        cr_next.st = C_IDLE;
        cr_next.tr[0] = RST_T0;
        cr_next.tr[1] = RST_TN;
        cr_next.tr[2] = RST_TN;
        cr_next.tr[3] = RST_TN;
    end
end

always_ff @(posedge clock_i) begin
    cr <= cr_next;
end

// ----------------------------------------
// link domain: cable sequencing
// ----------------------------------------
// even parity: write word absent, read mailbox free
assign even = (lk.mb_s == lk.lbt);
assign cap = lk.ud && !lk.wrd && !lk.dak && (lk.ry_s != lk.ry_d) &&
             (lk.st == L_XFER || lk.st == L_RPAU);

always_comb begin
    lk_next = lk;
    lk_next.rs_m = rst_n_i;
    lk_next.rs_s = lk.rs_m;
    lk_next.dq_m = drive_dma_request_i;
    lk_next.dq_s = lk.dq_m;
    lk_next.ry_m = cable_ready_input_i;
    lk_next.ry_s = lk.ry_m;
    lk_next.ry_d = lk.ry_s;
    lk_next.dm = cable_data_bus_i;
    lk_next.ds = lk.dm;
    lk_next.rn_m = cr.run;
    lk_next.rn_s = lk.rn_m;
    lk_next.hs_m = cr.hst;
    lk_next.hs_s = lk.hs_m;
    lk_next.mb_m = cr.mbt;
    lk_next.mb_s = lk.mb_m;
    if (lk.cnt != 5'h00) begin
        lk_next.cnt = lk.cnt - 5'h01;
    end
    if (cap) begin
        lk_next.crc = crc_upd(lk.crc, lk.ds);
        if (even) begin
            lk_next.lbd = lk.ds;
            lk_next.lbt = !lk.lbt;
        end else begin
            lk_next.err = 1'b1;
        end
    end
    unique case (lk.st)
        L_IDLE: begin
            lk_next.hak = lk.hs_s;
            if (!lk.rn_s) begin
                lk_next.err = 1'b0;
            end
            if (lk.rn_s && !lk.hs_s && lk.dq_s) begin
                lk_next.cs = 1'b0;
                lk_next.wrd = !cr.tom;
                lk_next.ud = cr.udma;
                lk_next.crc = CRC_SEED;
                lk_next.hak = 1'b0;
                lk_next.cnt = fld(cr.cfg, LSB_SETUP);
                lk_next.st = L_ACK;
            end
        end
        L_ACK: begin
            if (lk.cnt == 5'h00) begin
                lk_next.dak = 1'b0;
                lk_next.iow = !lk.ud;
                lk_next.ior = lk.ud ? lk.wrd : 1'b1;
                lk_next.st = lk.ud ? L_XFER : L_MREC;
            end
        end
        L_XFER: begin
            // strobe held until word and ready
            if (lk.wrd) begin
                if (!lk.dq_s || (lk.hs_s && even)) begin
                    lk_next.iow = 1'b1;
                    lk_next.cnt = fld(cr.cfg, LSB_PUL_SS);
                    lk_next.st = lk.dq_s ? L_STPW : L_SHI;
                end else if (!even && !lk.ry_s) begin
                    lk_next.dout = cr.mbd;
                    lk_next.doe = 1'b1;
                    lk_next.lbt = !lk.lbt;
                    lk_next.crc = crc_upd(lk.crc, cr.mbd);
                    lk_next.cnt = fld(cr.cfg, LSB_WRC_CYC) + 5'h01;
                    lk_next.st = L_WSET;
                end
            end else begin
                lk_next.ior = (lk.mb_s != lk_next.lbt);
                if (!lk.dq_s) begin
                    lk_next.iow = 1'b1;
                    lk_next.ior = 1'b1;
                    lk_next.cnt = fld(cr.cfg, LSB_PUL_SS);
                    lk_next.st = L_SHI;
                end else if (lk.hs_s) begin
                    lk_next.ior = 1'b1;
                    lk_next.cnt = fld(cr.cfg, LSB_WPL_RP);
                    lk_next.st = L_RPAU;
                end
            end
        end
        L_WSET: begin
            // host toggles strobe on reads line
            if (lk.cnt == 5'h00) begin
                lk_next.ior = !lk.ior;
                lk_next.st = L_XFER;
            end
        end
        L_RPAU: begin
            if (lk.cnt == 5'h00) begin
                lk_next.iow = 1'b1;
                lk_next.st = L_STPW;
            end
        end
        L_STPW: begin
            lk_next.cnt = fld(cr.cfg, LSB_PUL_SS);
            if (!lk.dq_s) begin
                lk_next.st = L_SHI;
            end
        end
        L_SHI: begin
            lk_next.ior = 1'b1;
            if (lk.cnt == 5'h00) begin
                lk_next.dout = lk.crc;
                lk_next.doe = 1'b1;
                lk_next.cnt = fld(cr.cfg, LSB_REC_CRC);
                lk_next.st = L_CRC;
            end
        end
        L_CRC: begin
            if (lk.cnt == 5'h00) begin
                lk_next.dak = 1'b1;
                lk_next.st = L_REL;
            end
        end
        L_REL: begin
            lk_next.doe = 1'b0;
            lk_next.cs = 1'b1;
            lk_next.iow = 1'b1;
            lk_next.ior = 1'b1;
            lk_next.st = L_IDLE;
        end
        L_MREC: begin
            if (lk.cnt == 5'h00) begin
                if (!lk.dq_s || (lk.hs_s && even)) begin
                    lk_next.dak = 1'b1;
                    lk_next.st = L_REL;
                end else if (lk.wrd && !even) begin
                    lk_next.dout = cr.mbd;
                    lk_next.doe = 1'b1;
                    lk_next.lbt = !lk.lbt;
                    lk_next.iow = 1'b0;
                    lk_next.cnt = fld(cr.cfg, LSB_WPL_RP);
                    lk_next.st = L_MPUL;
                end else if (!lk.wrd && even) begin
                    lk_next.ior = 1'b0;
                    lk_next.cnt = fld(cr.cfg, LSB_PUL_SS);
                    lk_next.st = L_MPUL;
                end
            end
        end
        L_MPUL: begin
            if (lk.cnt == 5'h00) begin
                lk_next.st = L_MREC;
                if (lk.wrd) begin
                    lk_next.iow = 1'b1;
                    lk_next.cnt = fld(cr.cfg, LSB_WRC_CYC);
                end else begin
                    lk_next.ior = 1'b1;
                    lk_next.lbd = lk.ds;
                    lk_next.lbt = !lk.lbt;
                    lk_next.cnt = fld(cr.cfg, LSB_REC_CRC);
                end
            end
        end
    endcase
    if (!lk.rs_s) begin
        lk_next = '0;
        lk_next.rs_m = rst_n_i;
        lk_next.rs_s = lk.rs_m;
        lk_next.st = L_IDLE;
        lk_next.crc = CRC_SEED;
        lk_next.iow = 1'b1;
        lk_next.ior = 1'b1;
        lk_next.dak = 1'b1;
        lk_next.cs = 1'b1;
    end
end

always_ff @(posedge link_clk_i) begin
    lk <= lk_next;
end

// ----------------------------------------
// outputs
// ----------------------------------------
assign reg_rdata_o = cr.rdat;
assign bm_active_o = cr.act;
assign bm_error_o = cr.err;
assign mem_rd_o = cr.rd;
assign mem_wr_o = cr.wr;
assign mem_addr_o = cr.adr;
assign mem_wdata_o = cr.wdat;
assign cable_write_strobe_n_o = lk.iow;
assign cable_read_strobe_n_o = lk.ior;
assign host_dma_acknowledge_n_o = lk.dak;
assign cable_chip_select_a_n_o = lk.cs;
assign cable_chip_select_b_n_o = lk.cs;
assign cable_register_addr_o = lk.adr;
assign cable_data_bus_o = lk.dout;
assign cable_data_bus_oe_o = lk.doe;

// ----------------------------------------
// checks
// ----------------------------------------
property p_ptr_step;
    @(posedge clock_i) disable iff (!rst_n_i)
    (cr.st == C_FB && mem_ack_i) |=> (cr.ptr == $past(cr.ptr) + PRD_STEP);
endproperty
a_ptr_step: assert property (p_ptr_step) else $error("pointer step");

property p_base;
    @(posedge clock_i) disable iff (!rst_n_i)
    (cr.st == C_FA && mem_ack_i) |=> (cr.badr[3:0] == 4'h0) && cr.st == C_FB;
endproperty
a_base: assert property (p_base) else $error("base not aligned");

property p_size;
    @(posedge clock_i) disable iff (!rst_n_i)
    (cr.st == C_FB && mem_ack_i) |=> (cr.rem[2:0] == 3'h0) && cr.rem != 16'h0;
endproperty
a_size: assert property (p_size) else $error("size not aligned");

property p_done;
    @(posedge clock_i) disable iff (!rst_n_i)
    (cr.st == C_FIN && cr.ak_s) |=> !bm_active_o ##1 !bm_active_o;
endproperty
a_done: assert property (p_done) else $error("active not cleared");

property p_pio;
    @(posedge clock_i) disable iff (!rst_n_i)
    (reg_rd_i && ri[2] && ri[1:0] != 2'h0 && cr.tr[0][B_PIOFMT]) |=> !reg_rdata_o[31];
endproperty
a_pio: assert property (p_pio) else $error("locked bit read");

property p_dack_sel;
    @(posedge link_clk_i) disable iff (!lk.rs_s)
    !lk.dak |-> !lk.cs && cable_register_addr_o == 3'h0;
endproperty
a_dack_sel: assert property (p_dack_sel) else $error("ack without select");

property p_crc_out;
    @(posedge link_clk_i) disable iff (!lk.rs_s)
    (lk.ud && $rose(lk.dak)) |-> lk.doe && lk.dout == lk.crc;
endproperty
a_crc_out: assert property (p_crc_out) else $error("crc not on bus");

property p_cycle;
    @(posedge link_clk_i) disable iff (!lk.rs_s)
    $rose(lk.st == L_WSET) |-> (lk.st == L_WSET)[*2];
endproperty
a_cycle: assert property (p_cycle) else $error("cycle too short");

property p_wr_wait;
    @(posedge link_clk_i) disable iff (!lk.rs_s)
    (lk.wrd && lk.st == L_XFER && lk.ry_s) |=> lk.st != L_WSET;
endproperty
a_wr_wait: assert property (p_wr_wait) else $error("strobe without ready");

property p_strobe_hi;
    @(posedge link_clk_i) disable iff (!lk.rs_s)
    (lk.st == L_CRC) |-> lk.ior && lk.iow;
endproperty
a_strobe_hi: assert property (p_strobe_hi) else $error("strobe low at end");

endmodule

// file: verif/udh_drive_model.sv
// Purpose: drive end of the cable for ultra write and read bursts
// Assumes: writes: DMARDY# stays asserted while engaged
// Notes:   stops requesting once STOP is seen; reads send eight words
`timescale 1ns/1ps
module udh_drive_model (
    // link side
    input  wire logic        link_clk_i,
    input  wire logic        go_i,
    input  wire logic        rd_i,
    input  wire logic        stop_i,
    input  wire logic        strobe_i,
    input  wire logic        ack_n_i,
    input  wire logic [15:0] data_i,
    // drive outputs
    output logic             dreq_o,
    output logic             ready_n_o,
    output logic      [15:0] data_o,
    output logic      [7:0]  words_o,
    output logic      [15:0] crc_o,
    output logic      [15:0] host_crc_o
);
    logic strobe_reg;
    logic ack_n_reg;
    logic done_reg;
    logic send_reg;
    logic armed_reg;
    logic phase_reg;
    function automatic logic [15:0] step(input logic [15:0] c, input logic [15:0] d);
        for (int i = 15; i >= 0; i--) begin
            c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0000);
        end
        return c;
    endfunction
    // ready line: strobe on reads, DMARDY# on writes
    assign ready_n_o = rd_i ? send_reg : ~go_i;
    always_ff @(posedge link_clk_i) begin
        strobe_reg <= strobe_i;
        ack_n_reg  <= ack_n_i;
        done_reg   <= go_i && (done_reg || (!ack_n_i && stop_i));
        dreq_o     <= go_i && !done_reg && !(!ack_n_i && stop_i);
        if (!go_i) begin
            words_o   <= 8'h00;
            crc_o     <= 16'h4ABA;
            data_o    <= 16'h0000;
            send_reg  <= 1'b1;
            armed_reg <= 1'b1;
            phase_reg <= 1'b0;
        end else if (rd_i) begin
            // host holds one word: wait for DMARDY# to drop and return
            if (strobe_i) begin
                armed_reg <= 1'b1;
            end
            // data one cycle ahead of the strobe edge
            if (phase_reg) begin
                send_reg  <= ~send_reg;
                phase_reg <= 1'b0;
                armed_reg <= 1'b0;
                words_o   <= words_o + 8'h01;
                crc_o     <= step(crc_o, data_o);
            end else if (!ack_n_i && !stop_i && !strobe_i && armed_reg && words_o < 8'h08) begin
                data_o    <= 16'hA5C3 ^ {8'h00, words_o};
                phase_reg <= 1'b1;
            end
        end else begin
            // bus not ours here: changing pattern
            data_o <= ~data_o;
            if (!ack_n_reg && !stop_i && strobe_i != strobe_reg) begin
                words_o <= words_o + 8'h01;
                crc_o   <= step(crc_o, data_i);
            end
        end
        if (ack_n_i && !ack_n_reg) begin
            host_crc_o <= data_i;
        end
    end
endmodule

// file: verif/udh_tb.sv
// Purpose: register, ultra write and ultra read burst checks
// Assumes: one descriptor of eight words
// Notes:   memory answers one cycle after a request, never on two cycles in a row
`timescale 1ns/1ps
module tb;
    import udh_pkg::*;
    logic        clock_i = 1'b0;
    logic        lclk    = 1'b0;
    logic        rst_n   = 1'b0;
    logic [7:0]  ra      = 8'h00;
    logic        rw      = 1'b0;
    logic        rr      = 1'b0;
    logic [31:0] wd      = 32'h0;
    logic        en      = 1'b0;
    logic        go      = 1'b0;
    logic        tom     = 1'b0;
    logic [1:0]  dsel    = 2'h0;
    logic        mack    = 1'b0;
    logic [31:0] mdat    = 32'h0;
    logic        seen    = 1'b0;
    logic [15:0] e       = CRC_SEED;
    logic [15:0] er      = CRC_SEED;
    logic [31:0] rd, maddr;
    logic        act, err, mrd, mwr, dreq, rdy, stp, stb, dackn, csa, csb;
    logic [2:0]  cad;
    logic [15:0] din, dout, dcrc, hcrc, mwd, bus;
    logic        doe;
    logic [7:0]  words;
    int          num_errors = 0;
    int          n_tests    = 0;
    int          wk         = 0;

    udh_top DUT (.clock_i(clock_i), .rst_n_i(rst_n), .reg_addr_i(ra), .reg_wr_i(rw),
        .reg_rd_i(rr), .reg_wdata_i(wd), .reg_rdata_o(rd), .bm_enable_i(en),
        .bm_to_memory_i(tom), .prd_table_addr_i(32'h00000200), .drive_select_i(dsel),
        .bm_active_o(act), .bm_error_o(err), .mem_rd_o(mrd), .mem_wr_o(mwr),
        .mem_addr_o(maddr), .mem_wdata_o(mwd), .mem_ack_i(mack), .mem_rdata_i(mdat),
        .link_clk_i(lclk), .drive_dma_request_i(dreq), .cable_ready_input_i(rdy),
        .cable_data_bus_i(din), .cable_write_strobe_n_o(stp), .cable_read_strobe_n_o(stb),
        .host_dma_acknowledge_n_o(dackn), .cable_chip_select_a_n_o(csa),
        .cable_chip_select_b_n_o(csb), .cable_register_addr_o(cad),
        .cable_data_bus_o(dout), .cable_data_bus_oe_o(doe));
    // released bus shows garbage, so a missing enable corrupts words and CRC
    assign bus = doe ? dout : ~dout;
    udh_drive_model DRV (.link_clk_i(lclk), .go_i(go), .rd_i(tom), .stop_i(stp),
        .strobe_i(stb), .ack_n_i(dackn), .data_i(bus), .dreq_o(dreq), .ready_n_o(rdy),
        .data_o(din), .words_o(words), .crc_o(dcrc), .host_crc_o(hcrc));

    initial forever #25 clock_i = ~clock_i;
    initial begin
        #3;
        forever #6 lclk = ~lclk;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            num_errors++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        ra <= a;
        wd <= d;
        rw <= 1'b1;
        @(posedge clock_i);
        rw <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock_i);
        ra <= a;
        rr <= 1'b1;
        @(posedge clock_i);
        rr <= 1'b0;
        #1 chk($sformatf("reg %h", a), exp, rd);
    endtask
    task automatic burst(input logic dir, input logic [1:0] drv, input logic [15:0] exp);
        seen = 1'b0;
        tom  <= dir;
        dsel <= drv;
        go   <= 1'b1;
        en   <= 1'b1;
        for (int i = 0; i < 4000; i++) begin
            @(posedge clock_i);
            if (act) seen = 1'b1;
            if (seen && !act) break;
        end
        repeat (10) @(posedge clock_i);
        chk("run seen", 1'b1, seen);
        chk("run ended", 1'b0, act);
        chk("error", 1'b0, err);
        chk("words", 8'h08, words);
        chk("drive crc", exp, dcrc);
        chk("host crc", exp, hcrc);
        chk("drive crc compare", dcrc, hcrc);
        en <= 1'b0;
        go <= 1'b0;
        repeat (4) @(posedge clock_i);
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    always @(posedge clock_i) begin
        mack <= (mrd || mwr) && !mack;
        mdat <= (maddr == 32'h200) ? 32'h100 : (maddr == 32'h204) ? 32'h80000010
              : {16'h0000, maddr[15:0] ^ 16'h5A3C};
        if (mwr && mack) begin
            chk("memory address", 32'h100 + 32'(2 * wk), maddr);
            chk("memory write", 16'hA5C3 ^ 16'(wk), mwd);
            wk++;
        end
    end
    always @(posedge lclk) begin
        if (!dackn) chk("selects and address", 5'h00, {csa, csb, cad});
    end

    initial begin
        repeat (16) @(posedge clock_i);
        rst_n <= 1'b1;
        repeat (4) @(posedge clock_i);
        rdchk(OFS_T0, 32'h00077771);
        rdchk(OFS_T1, 32'h00017771);
        rdchk(OFS_T2, 32'h00017771);
        rdchk(OFS_T3, 32'h00017771);
        rdchk(8'h28, 32'h0);
        wr(OFS_T1, 32'hFFFFFFFF);
        rdchk(OFS_T1, 32'h801FFFFF);
        wr(OFS_T0, 32'h80000000);
        wr(OFS_T3, 32'hFFFFFFFF);
        rdchk(OFS_T3, 32'h001FFFFF);
        $display("register test done");
        wr(OFS_T0, 32'h00100000);
        for (int k = 0; k < 8; k++) begin
            e  = DRV.step(e, (16'h0100 + 16'(2 * k)) ^ 16'h5A3C);
            er = DRV.step(er, 16'hA5C3 ^ 16'(k));
        end
        burst(1'b0, 2'h0, e);
        $display("ultra write test done");
        burst(1'b1, 2'h1, er);
        chk("memory words", 32'h8, wk);
        $display("ultra read test done");
        results();
    end
    initial begin
        #1000000;
        num_errors++;
        results();
    end
endmodule
